//--- logic/phymr_defines.vh
// Constants for the management register bank: addresses, bit classes, resets
`ifndef PHYMR_DEFINES_VH
`define PHYMR_DEFINES_VH

`define PHYMR_DW            16
`define PHYMR_AW            5
`define PHYMR_ALL_ONES      16'hffff
`define PHYMR_ZERO          16'h0000

// Register addresses
`define PHYMR_A_BASIC_CTRL  5'h00
`define PHYMR_A_BASIC_STAT  5'h01
`define PHYMR_A_ID_HIGH     5'h02
`define PHYMR_A_ID_LOW      5'h03
`define PHYMR_A_AN_ADV      5'h04
`define PHYMR_A_AN_LPA      5'h05
`define PHYMR_A_AN_EXP      5'h06
`define PHYMR_A_AN_NP_TX    5'h07
`define PHYMR_A_AN_LP_NP    5'h08
`define PHYMR_A_STD_LAST    5'h08
`define PHYMR_A_VEND_CTRL   5'h10
`define PHYMR_A_QPOLL       5'h11
`define PHYMR_A_TEN_OPS     5'h12
`define PHYMR_A_VEND_CTRL2  5'h13

// Command override bit in the vendor extended control register
`define PHYMR_OVR_BIT       15
// Preamble suppression bit in the basic status register
`define PHYMR_PRE_SUP_BIT   6

// Per-register class masks: read-only, override-gated, read/write, write-zero-only
`define PHYMR_RO_0          16'h007f
`define PHYMR_CW_0          16'h0000
`define PHYMR_RW_0          16'hff80
`define PHYMR_W0_0          16'h0000
`define PHYMR_RST_0         16'h3000

`define PHYMR_RO_1          16'hffbf
`define PHYMR_CW_1          16'h0040
`define PHYMR_RW_1          16'h0000
`define PHYMR_W0_1          16'h0000
`define PHYMR_RST_1         16'h0000

`define PHYMR_RO_4          16'h4000
`define PHYMR_RW_4          16'hbfff
`define PHYMR_RST_4         16'h01e1

`define PHYMR_RO_7          16'h4800
`define PHYMR_RW_7          16'hb7ff
`define PHYMR_RST_7         16'h2001

`define PHYMR_RO_16         16'h87c0
`define PHYMR_CW_16         16'h7800
`define PHYMR_RW_16         16'h003f
`define PHYMR_RST_16        16'h0000

`define PHYMR_RO_18         16'h03ff
`define PHYMR_RW_18         16'he000
`define PHYMR_W0_18         16'h1c00
`define PHYMR_RST_18        16'h1c00

`define PHYMR_CW_19         16'h8000
`define PHYMR_RW_19         16'h7fff
`define PHYMR_RST_19        16'h0000

// Fixed read-only contents of registers without a live source
`define PHYMR_RST_6         16'h0004
`define PHYMR_RST_8         16'h0000

`endif

//--- logic/phymr_reg_cell.v
// One 16-bit management register with per-bit access classes
`timescale 1ns/1ps
`include "phymr_defines.vh"

module phymr_reg_cell #(
  parameter [15:0] RST_VAL = 16'h0000,
  parameter [15:0] RO_MASK = 16'hffff,
  parameter [15:0] CW_MASK = 16'h0000,
  parameter [15:0] RW_MASK = 16'h0000,
  parameter [15:0] W0_MASK = 16'h0000
) (
  input  wire        clk_sys,     // System clock
  input  wire        resetn,      // Async reset, active low
  input  wire        wr_en,       // Write strobe for this register
  input  wire [15:0] wdata,       // Write data
  input  wire        override,    // Override-gated bits writable
  input  wire [15:0] hw_val,      // Live value of read-only bits
  output wire [15:0] rd_val,      // Value returned on a read
  output wire [15:0] stored       // Stored value, read-only bits zero
);

  reg  [15:0] val_reg;
  wire [15:0] val_next;

  ////////////////////////////////////////////////////////////////////////////
  // Each class merges its own slice; read-only bits never take write data
  assign val_next = (wdata & RW_MASK)                                       // see RULE7
                  | ((override ? wdata : val_reg) & CW_MASK)               // see RULE4
                  | (val_reg & wdata & W0_MASK);                           // see RULE8

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      val_reg <= RST_VAL & ~RO_MASK;
    end else if (wr_en) begin
      val_reg <= val_next;                                                  // see RULE3
    end
  end

  assign stored = val_reg;
  assign rd_val = (val_reg & ~RO_MASK) | (hw_val & RO_MASK);                // see RULE3

endmodule // phymr_reg_cell

//--- logic/phymr_override_ctl.v
// Single-shot command override flag
`timescale 1ns/1ps
`include "phymr_defines.vh"

module phymr_override_ctl (
  input  wire clk_sys,     // System clock
  input  wire resetn,      // Async reset, active low
  input  wire wr_impl,     // Write to an implemented register
  input  wire wr_ovr_reg,  // That write targets the override register
  input  wire wr_ovr_bit,  // Write data bit of the override flag
  output wire override     // Flag, applies to the next write
);

  reg override_reg;

  ////////////////////////////////////////////////////////////////////////////
  // A pending flag is consumed by the very next implemented write, even one
  // that writes the flag again, so one set grants exactly one write.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      override_reg <= 1'b0;                                                 // see RULE4
    end else if (wr_impl) begin
      if (override_reg) begin
        override_reg <= 1'b0;                                               // see RULE6
      end else if (wr_ovr_reg && wr_ovr_bit) begin
        override_reg <= 1'b1;                                               // see RULE5
      end
    end
  end

  assign override = override_reg;

endmodule // phymr_override_ctl

//--- logic/phymr_reg_bank.v
// Management register bank of the transceiver, behind the decoded frame port
// Function
// RULE1: Decode 0 control, 1 status, 2-3 identifier, 4-8 autoneg; 9-15 reserved.
// RULE2: Vendor registers 16 to 19 implemented; addresses 20 to 31 reserved.
// RULE3: Read-only bits read their value; writes to them are dropped.
// RULE4: Override-gated bits always readable; writes dropped while override bit is zero.
// RULE5: With override set, the next write may change gated bits; manager sets first.
// RULE6: Override bit clears itself on the write following its setting.
// RULE7: Read/write bits store written data and read it back unconditionally.
// RULE8: Write-zero-only bits are readable; writes can clear but never set them.
// RULE9: Every management register is sixteen bits wide.
// RULE10: Reads of unimplemented addresses return all ones; writes reach nothing.
// RULE11: Preamble suppression bit is override-gated, default zero.
// RULE12: Writes to reserved addresses have no effect, nor consume the override.
`timescale 1ns/1ps
`include "phymr_defines.vh"

module phymr_reg_bank #(
  parameter [15:0] ID_HIGH = 16'h1234,  // Arbitrary identifier value
  parameter [15:0] ID_LOW  = 16'h5678   // Arbitrary identifier value
) (
  input  wire        clk_sys,          // System clock, 25 MHz
  input  wire        resetn,           // Async reset, active low
  input  wire        mgmt_wr_en,       // Write request, one-cycle pulse
  input  wire        mgmt_rd_en,       // Read request, one-cycle pulse
  input  wire [4:0]  mgmt_addr,        // Register address of the frame
  input  wire [15:0] mgmt_wdata,       // Write data of the frame
  output reg  [15:0] mgmt_rdata,       // Read data, held until next read
  output reg         mgmt_rvalid,      // Read data valid, one-cycle pulse
  input  wire [15:0] status_in,        // Live basic status bits
  input  wire [15:0] partner_ability_in, // Live partner ability word
  input  wire [15:0] quick_poll_in,    // Live quick-poll status word
  input  wire [4:0]  phy_addr_in,      // Station address shown in reg 16
  input  wire [9:0]  ten_mbit_in,      // Live 10 Mb/s status bits
  output wire [15:0] basic_control,    // Stored control word
  output wire [15:0] autoneg_adv,      // Stored advertisement word
  output wire [15:0] ext_control,      // Stored vendor control word
  output wire [15:0] ext_control_two,  // Stored second vendor control word
  output wire [15:0] ten_mbit_ctrl,    // Stored 10 Mb/s control word
  output wire        preamble_sup_en,  // Preamble suppression enabled
  output wire        override_pending  // Override flag is armed
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function addr_impl;
    input [4:0] a;
    reg         std_hit;
    reg         vend_hit;
    begin
      std_hit   = (a <= `PHYMR_A_STD_LAST);                                 // see RULE1
      vend_hit  = (a >= `PHYMR_A_VEND_CTRL) && (a <= `PHYMR_A_VEND_CTRL2);  // see RULE2
      addr_impl = std_hit || vend_hit;
    end
  endfunction

  function hit;
    input [4:0] a;
    input [4:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  wire        override;
  wire        wr_impl;
  wire        we_r0;
  wire        we_r1;
  wire        we_r4;
  wire        we_r7;
  wire        we_r16;
  wire        we_r18;
  wire        we_r19;

  wire [15:0] rv0;
  wire [15:0] rv1;
  wire [15:0] rv2;
  wire [15:0] rv3;
  wire [15:0] rv4;
  wire [15:0] rv5;
  wire [15:0] rv6;
  wire [15:0] rv7;
  wire [15:0] rv8;
  wire [15:0] rv16;
  wire [15:0] rv17;
  wire [15:0] rv18;
  wire [15:0] rv19;
  wire [15:0] st1;
  wire [15:0] hw16;
  wire [15:0] hw18;
  wire [15:0] rd_mux;

  // Reserved addresses never strobe a cell nor the override flag
  assign wr_impl = mgmt_wr_en && addr_impl(mgmt_addr);                      // see RULE10 RULE12

  phymr_override_ctl u_ovr (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .wr_impl    (wr_impl),
    .wr_ovr_reg (hit(mgmt_addr, `PHYMR_A_VEND_CTRL)),
    .wr_ovr_bit (mgmt_wdata[`PHYMR_OVR_BIT]),
    .override   (override)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes, one per stored register

  assign we_r0  = wr_impl && hit(mgmt_addr, `PHYMR_A_BASIC_CTRL);
  assign we_r1  = wr_impl && hit(mgmt_addr, `PHYMR_A_BASIC_STAT);
  assign we_r4  = wr_impl && hit(mgmt_addr, `PHYMR_A_AN_ADV);
  assign we_r7  = wr_impl && hit(mgmt_addr, `PHYMR_A_AN_NP_TX);
  assign we_r16 = wr_impl && hit(mgmt_addr, `PHYMR_A_VEND_CTRL);
  assign we_r18 = wr_impl && hit(mgmt_addr, `PHYMR_A_TEN_OPS);
  assign we_r19 = wr_impl && hit(mgmt_addr, `PHYMR_A_VEND_CTRL2);

  ////////////////////////////////////////////////////////////////////////////
  // Standard registers

  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_0),
    .RO_MASK (`PHYMR_RO_0),
    .CW_MASK (`PHYMR_CW_0),
    .RW_MASK (`PHYMR_RW_0),
    .W0_MASK (`PHYMR_W0_0)
  ) u_r0 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r0),
    .wdata    (mgmt_wdata),
    .override (override),
    .hw_val   (`PHYMR_RST_0),
    .rd_val   (rv0),
    .stored   (basic_control)
  );

  // Status word: live read-only bits plus the gated suppression bit
  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_1),
    .RO_MASK (`PHYMR_RO_1),
    .CW_MASK (`PHYMR_CW_1),
    .RW_MASK (`PHYMR_RW_1),
    .W0_MASK (`PHYMR_W0_1)
  ) u_r1 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r1),
    .wdata    (mgmt_wdata),
    .override (override),                                                   // see RULE11
    .hw_val   (status_in),
    .rd_val   (rv1),
    .stored   (st1)
  );

  assign preamble_sup_en = st1[`PHYMR_PRE_SUP_BIT];                         // see RULE11

  // Fully read-only registers need no storage
  assign rv2 = ID_HIGH;                                                     // see RULE3
  assign rv3 = ID_LOW;                                                      // see RULE3
  assign rv5 = partner_ability_in;                                          // see RULE3
  assign rv6 = `PHYMR_RST_6;                                                // see RULE3
  assign rv8 = `PHYMR_RST_8;                                                // see RULE3

  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_4),
    .RO_MASK (`PHYMR_RO_4),
    .CW_MASK (`PHYMR_ZERO),
    .RW_MASK (`PHYMR_RW_4),
    .W0_MASK (`PHYMR_ZERO)
  ) u_r4 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r4),
    .wdata    (mgmt_wdata),
    .override (override),
    .hw_val   (`PHYMR_RST_4),
    .rd_val   (rv4),
    .stored   (autoneg_adv)
  );

  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_7),
    .RO_MASK (`PHYMR_RO_7),
    .CW_MASK (`PHYMR_ZERO),
    .RW_MASK (`PHYMR_RW_7),
    .W0_MASK (`PHYMR_ZERO)
  ) u_r7 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r7),
    .wdata    (mgmt_wdata),
    .override (override),
    .hw_val   (`PHYMR_RST_7),
    .rd_val   (rv7),
    .stored   ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Vendor registers

  // Override flag and station address appear as read-only bits here
  assign hw16 = {override,
                 {4{1'b0}},
                 phy_addr_in,
                 {6{1'b0}}};

  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_16),
    .RO_MASK (`PHYMR_RO_16),
    .CW_MASK (`PHYMR_CW_16),
    .RW_MASK (`PHYMR_RW_16),
    .W0_MASK (`PHYMR_ZERO)
  ) u_r16 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r16),
    .wdata    (mgmt_wdata),
    .override (override),                                                   // see RULE5
    .hw_val   (hw16),
    .rd_val   (rv16),
    .stored   (ext_control)
  );

  assign rv17 = quick_poll_in;                                              // see RULE3

  assign hw18 = {{6{1'b0}},
                 ten_mbit_in};

  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_18),
    .RO_MASK (`PHYMR_RO_18),
    .CW_MASK (`PHYMR_ZERO),
    .RW_MASK (`PHYMR_RW_18),
    .W0_MASK (`PHYMR_W0_18)
  ) u_r18 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r18),
    .wdata    (mgmt_wdata),
    .override (override),
    .hw_val   (hw18),
    .rd_val   (rv18),
    .stored   (ten_mbit_ctrl)
  );

  phymr_reg_cell #(
    .RST_VAL (`PHYMR_RST_19),
    .RO_MASK (`PHYMR_ZERO),
    .CW_MASK (`PHYMR_CW_19),
    .RW_MASK (`PHYMR_RW_19),
    .W0_MASK (`PHYMR_ZERO)
  ) u_r19 (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (we_r19),
    .wdata    (mgmt_wdata),
    .override (override),
    .hw_val   (`PHYMR_ZERO),
    .rd_val   (rv19),
    .stored   (ext_control_two)
  );

  assign override_pending = override;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  reg [15:0] rd_sel;

  always @* begin
    case (mgmt_addr)
      `PHYMR_A_BASIC_CTRL: rd_sel = rv0;                                    // see RULE1
      `PHYMR_A_BASIC_STAT: rd_sel = rv1;
      `PHYMR_A_ID_HIGH:    rd_sel = rv2;
      `PHYMR_A_ID_LOW:     rd_sel = rv3;
      `PHYMR_A_AN_ADV:     rd_sel = rv4;
      `PHYMR_A_AN_LPA:     rd_sel = rv5;
      `PHYMR_A_AN_EXP:     rd_sel = rv6;
      `PHYMR_A_AN_NP_TX:   rd_sel = rv7;
      `PHYMR_A_AN_LP_NP:   rd_sel = rv8;
      `PHYMR_A_VEND_CTRL:  rd_sel = rv16;                                   // see RULE2
      `PHYMR_A_QPOLL:      rd_sel = rv17;
      `PHYMR_A_TEN_OPS:    rd_sel = rv18;
      `PHYMR_A_VEND_CTRL2: rd_sel = rv19;
      default:             rd_sel = `PHYMR_ALL_ONES;                        // see RULE10
    endcase
  end

  assign rd_mux = addr_impl(mgmt_addr) ? rd_sel                             // see RULE10
                                       : `PHYMR_ALL_ONES;

  // Valid follows the read strobe by one cycle, whatever the address
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd_en;
    end
  end

  // Data is a 16-bit word, matching the frame's data field; held between reads
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mgmt_rdata <= `PHYMR_ZERO;
    end else if (mgmt_rd_en) begin
      mgmt_rdata <= rd_mux;                                                 // see RULE9
    end
  end

endmodule // phymr_reg_bank

//--- dv/phymr_sta_model.sv
// Station manager model issuing reads and writes on the decoded register port
`timescale 1ns/1ps
module phymr_sta_model (
  input  wire         clk_sys,     // System clock
  output logic        mgmt_wr_en,  // Write strobe
  output logic        mgmt_rd_en,  // Read strobe
  output logic [4:0]  mgmt_addr,   // Register address
  output logic [15:0] mgmt_wdata,  // Write data
  input  wire  [15:0] mgmt_rdata,  // Read data
  input  wire         mgmt_rvalid  // Read data valid
);
  initial begin
    mgmt_wr_en = 1'b0;
    mgmt_rd_en = 1'b0;
    mgmt_addr  = 5'h1f;
    mgmt_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // A back-to-back write leaves the strobe up, so only another write may follow
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input bit bb);
    @(posedge clk_sys);
    mgmt_wr_en <= 1'b1;
    mgmt_addr  <= a;
    mgmt_wdata <= d;
    if (!bb) begin
      @(posedge clk_sys);
      mgmt_wr_en <= 1'b0;
      mgmt_addr  <= ~a;
      mgmt_wdata <= ~d;
      #1;
    end
  endtask
  // Released lines show the inverse, never a stale copy
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    mgmt_rd_en <= 1'b1;
    mgmt_addr  <= a;
    @(posedge clk_sys);
    mgmt_rd_en <= 1'b0;
    mgmt_addr  <= ~a;
    #1;
    d = mgmt_rvalid ? mgmt_rdata : 16'hxxxx;
  endtask
endmodule // phymr_sta_model

//--- dv/phymr_reg_bank_checker.sv
// Assertions on the ports of the management register bank
`timescale 1ns/1ps
module phymr_reg_bank_checker #(
  parameter [15:0] ID_HIGH = 16'h1234,  // Arbitrary identifier value
  parameter [15:0] ID_LOW  = 16'h5678   // Arbitrary identifier value
) (
  input wire        clk_sys,            // Clock
  input wire        resetn,             // Reset, active low
  input wire        mgmt_wr_en,         // Write strobe
  input wire        mgmt_rd_en,         // Read strobe
  input wire [4:0]  mgmt_addr,          // Address
  input wire [15:0] mgmt_wdata,         // Write data
  input wire [15:0] mgmt_rdata,         // Read data
  input wire        mgmt_rvalid,        // Read valid
  input wire [15:0] status_in,          // Live status
  input wire [15:0] partner_ability_in, // Live partner word
  input wire [15:0] quick_poll_in,      // Live poll word
  input wire [4:0]  phy_addr_in,        // Station address
  input wire [9:0]  ten_mbit_in,        // Live 10 Mb/s bits
  input wire [15:0] basic_control,      // Stored reg 0
  input wire [15:0] autoneg_adv,        // Stored reg 4
  input wire [15:0] ext_control,        // Stored reg 16
  input wire [15:0] ext_control_two,    // Stored reg 19
  input wire [15:0] ten_mbit_ctrl,      // Stored reg 18
  input wire        preamble_sup_en,    // Reg 1 bit 6
  input wire        override_pending    // Override flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire impl = (mgmt_addr <= 5'h08) || (mgmt_addr >= 5'h10 && mgmt_addr <= 5'h13);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_arm; !override_pending && mgmt_wr_en && mgmt_addr == 5'h10
    && mgmt_wdata[15]; endsequence
  sequence s_use; override_pending && mgmt_wr_en && impl; endsequence
  property p_arm; s_arm |=> override_pending; endproperty
  property p_clr; s_use |=> !override_pending; endproperty
  property p_keep; override_pending && !(mgmt_wr_en && impl) |=> override_pending; endproperty
  property p_pre; s_use ##0 mgmt_addr == 5'h01 |=> preamble_sup_en == $past(mgmt_wdata[6]);
  endproperty
  property p_gate; !override_pending && mgmt_wr_en |=> $stable(preamble_sup_en)
    && ext_control[14:11] == $past(ext_control[14:11])
    && ext_control_two[15] == $past(ext_control_two[15]);
  endproperty
  property p_resv; mgmt_wr_en && !impl |=> $stable(basic_control) && $stable(ext_control_two)
    && $stable(ten_mbit_ctrl) && $stable(ext_control);
  endproperty
  property p_w0; mgmt_wr_en && mgmt_addr == 5'h12 |=>
    ten_mbit_ctrl[12:10] == ($past(ten_mbit_ctrl[12:10]) & $past(mgmt_wdata[12:10]));
  endproperty
  property p_rw; mgmt_wr_en && mgmt_addr == 5'h13 |=>
    ext_control_two[14:0] == $past(mgmt_wdata[14:0]);
  endproperty
  property p_unimpl; mgmt_rd_en && !impl |=> mgmt_rvalid && mgmt_rdata == 16'hffff; endproperty
  property p_id; mgmt_rd_en && mgmt_addr == 5'h02 |=>
    mgmt_rvalid && mgmt_rdata == ID_HIGH; endproperty
  property p_live; mgmt_rd_en && mgmt_addr == 5'h05 |=> mgmt_rdata == $past(partner_ability_in);
  endproperty
  a_arm: assert property (p_arm) else $error("override not armed");
  a_clr: assert property (p_clr) else $error("override not cleared");
  a_keep: assert property (p_keep) else $error("override lost");
  a_pre: assert property (p_pre) else $error("preamble bit not written");
  a_gate: assert property (p_gate) else $error("gated bit changed");
  a_resv: assert property (p_resv) else $error("reserved write landed");
  a_w0: assert property (p_w0) else $error("write-zero-only bit set");
  a_rw: assert property (p_rw) else $error("read/write bits wrong");
  a_unimpl: assert property (p_unimpl) else $error("unimplemented read wrong");
  a_id: assert property (p_id) else $error("identifier read wrong");
  a_live: assert property (p_live) else $error("read-only read wrong");
endmodule // phymr_reg_bank_checker

//--- dv/phy_mgmt_register_access_tb.sv
// Self-checking bench for the management register bank
`timescale 1ns/1ps
module phy_mgmt_register_access_tb;
  localparam [15:0] ID_HIGH = 16'h2a3c;  // Arbitrary identifier value
  localparam [15:0] ID_LOW  = 16'h0d71;  // Arbitrary identifier value
  logic clk_sys, resetn;
  wire mgmt_wr_en, mgmt_rd_en, mgmt_rvalid, preamble_sup_en, override_pending;
  wire [4:0] mgmt_addr;
  wire [15:0] mgmt_wdata, mgmt_rdata, basic_control, autoneg_adv, ext_control;
  wire [15:0] ext_control_two, ten_mbit_ctrl;
  logic [15:0] status_in, partner_ability_in, quick_poll_in;
  logic [4:0] phy_addr_in;
  logic [9:0] ten_mbit_in;
  int n_mismatch, checks_done, cycles;
  phymr_reg_bank #(.ID_HIGH(ID_HIGH), .ID_LOW(ID_LOW)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .status_in(status_in), .partner_ability_in(partner_ability_in),
    .quick_poll_in(quick_poll_in), .phy_addr_in(phy_addr_in), .ten_mbit_in(ten_mbit_in),
    .basic_control(basic_control), .autoneg_adv(autoneg_adv), .ext_control(ext_control),
    .ext_control_two(ext_control_two), .ten_mbit_ctrl(ten_mbit_ctrl),
    .preamble_sup_en(preamble_sup_en), .override_pending(override_pending));
  phymr_sta_model sta (.clk_sys(clk_sys), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    sta.rd(a, d);
    chk(d, exp);
  endtask
  // Read image straight after reset
  function automatic logic [15:0] exp_rd(input logic [4:0] a);
    case (a)
      5'h00: exp_rd = 16'h3000;
      5'h01: exp_rd = status_in & 16'hffbf;
      5'h02: exp_rd = ID_HIGH;
      5'h03: exp_rd = ID_LOW;
      5'h04: exp_rd = 16'h01e1;
      5'h05: exp_rd = partner_ability_in;
      5'h06: exp_rd = 16'h0004;
      5'h07: exp_rd = 16'h2001;
      5'h08: exp_rd = 16'h0000;
      5'h10: exp_rd = {5'h00, phy_addr_in, 6'h00};
      5'h11: exp_rd = quick_poll_in;
      5'h12: exp_rd = {6'h07, ten_mbit_in};
      5'h13: exp_rd = 16'h0000;
      default: exp_rd = 16'hffff;
    endcase
  endfunction
  task automatic t_reset();
    chk(basic_control, 16'h3000);
    chk(autoneg_adv, 16'h01e1);
    chk(ext_control, 16'h0000);
    chk(ext_control_two, 16'h0000);
    chk(ten_mbit_ctrl, 16'h1c00);
    chk({15'h0000, preamble_sup_en}, 16'h0000);
    chk({15'h0000, override_pending}, 16'h0000);
  endtask
  task automatic t_decode();
    for (int a = 0; a < 32; a++) begin
      rdc(a[4:0], exp_rd(a[4:0]));
    end
  endtask
  task automatic t_classes();
    sta.wr(5'h00, 16'hffff, 1'b0);
    chk(basic_control, 16'hff80);
    sta.wr(5'h13, 16'hffff, 1'b0);
    rdc(5'h13, 16'h7fff);
    sta.wr(5'h12, 16'h1400, 1'b0);
    chk(ten_mbit_ctrl, 16'h1400);
    sta.wr(5'h12, 16'hfc00, 1'b0);
    rdc(5'h12, {6'h3d, ten_mbit_in});
    sta.wr(5'h04, 16'hffff, 1'b0);
    chk(autoneg_adv, 16'hbfff);
    sta.wr(5'h07, 16'hffff, 1'b0);
    rdc(5'h07, 16'hb7ff);
    sta.wr(5'h02, 16'h0000, 1'b0);
    rdc(5'h02, ID_HIGH);
  endtask
  task automatic t_override();
    sta.wr(5'h01, 16'h0040, 1'b0);
    chk({15'h0000, preamble_sup_en}, 16'h0000);
    sta.wr(5'h10, 16'h8000, 1'b0);
    chk({15'h0000, override_pending}, 16'h0001);
    sta.wr(5'h0a, 16'hffff, 1'b0);
    sta.wr(5'h15, 16'hffff, 1'b0);
    chk({15'h0000, override_pending}, 16'h0001);
    chk(ext_control, 16'h0000);
    // Gated write and an ungated one back to back
    sta.wr(5'h01, 16'h0040, 1'b1);
    sta.wr(5'h10, 16'h7fff, 1'b0);
    chk({15'h0000, preamble_sup_en}, 16'h0001);
    chk({15'h0000, override_pending}, 16'h0000);
    chk(ext_control, 16'h003f);
    rdc(5'h01, (status_in & 16'hffbf) | 16'h0040);
    sta.wr(5'h10, 16'h8000, 1'b0);
    sta.wr(5'h10, 16'hffff, 1'b0);
    chk(ext_control, 16'h783f);
    chk({15'h0000, override_pending}, 16'h0000);
    sta.wr(5'h10, 16'h8000, 1'b0);
    sta.wr(5'h13, 16'h8000, 1'b0);
    chk(ext_control_two, 16'h8000);
  endtask
  task automatic end_of_test();
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Whole run is about 124 cycles; the ceiling leaves ample slack
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    resetn = 1'b0;
    status_in = 16'h7809;
    partner_ability_in = 16'h45e1;
    quick_poll_in = 16'h9a52;
    phy_addr_in = 5'h15;
    ten_mbit_in = 10'h2a5;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_decode();
    t_classes();
    t_override();
    end_of_test();
  end
endmodule // phy_mgmt_register_access_tb

bind phymr_reg_bank phymr_reg_bank_checker #(.ID_HIGH(ID_HIGH), .ID_LOW(ID_LOW)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .mgmt_rvalid(mgmt_rvalid), .status_in(status_in), .partner_ability_in(partner_ability_in),
  .quick_poll_in(quick_poll_in), .phy_addr_in(phy_addr_in), .ten_mbit_in(ten_mbit_in),
  .basic_control(basic_control), .autoneg_adv(autoneg_adv), .ext_control(ext_control),
  .ext_control_two(ext_control_two), .ten_mbit_ctrl(ten_mbit_ctrl),
  .preamble_sup_en(preamble_sup_en), .override_pending(override_pending));
